/* File: verilog/hdlc_bit_code_ds0_config.sv */
/*
 HDLC / bit-oriented-code configuration block of a T1 framer:
 transmit code register, transmit FIFO port, receive channel
 and bit-suppress registers, with the transmit serialiser and
 receive bit selector they steer.
 Assumes the control port strobes are synchronous to i_clk and
 the framer gives one-cycle bit strobes on i_clk.
*/
// Summary of operation
// [RL1] Source bit picks link pin or controller
// [RL2] Codeword bit 5 goes out last
// [RL3] Codeword bit 0 goes out first
// [RL4] FIFO port write pushes one byte
// [RL5] FIFO byte bit 7 is MSB
// [RL6] Enable bit picks link or DS0 channels
// [RL7] Mode 0 uses the single selected channel
// [RL8] Mode 1 uses the channel block map
// [RL9] Channel field is binary, bit 0 LSB
// [RL10] Suppress bit 7 drops DS0 bit 8
// [RL11] Suppress bits 0-6 drop DS0 bits 1-7
// [RL12] Host writes zero to spare bit 6
// [RL13] Rising trigger starts code, clearing stops
// [RL14] Suppressed bits are skipped entirely
`timescale 1ns/100ps

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output wire logic             o_in_ready,
   output wire logic             o_out_valid,
   output wire logic [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;

   // Handshakes and wrap-around pointers
   wire          push     = i_in_valid & o_in_ready;
   wire          pop      = o_out_valid & i_out_ready;
   wire [AW-1:0] wr_nxt   = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
   wire [AW-1:0] rd_nxt   = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
   assign o_in_ready  = (count_r != CW'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];

   // Storage needs no reset; count guards every read
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_nxt;
         if (pop) rd_ptr_r <= rd_nxt;
         if (push && !pop) count_r <= count_r + 1'b1;
         else if (pop && !push) count_r <= count_r - 1'b1;
      end
   end
endmodule

module hdlc_bit_code_ds0_config
   import hdlc_cfg_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output wire logic [7:0]  o_rdata,
   output wire logic        o_fifo_ready,
   input  wire logic        i_tx_fdl_en,
   input  wire logic        i_transmit_link_input,
   output wire logic        o_tx_fdl_bit,
   output wire logic        o_sending_code,
   input  wire logic        i_rx_bit_en,
   input  wire logic        i_rx_bit,
   input  wire logic        i_rx_fdl_slot,
   input  wire logic [4:0]  i_rx_chan,
   input  wire logic [2:0]  i_rx_bitpos,
   input  wire logic        i_rx_block_hit,
   output wire logic        o_rx_hdlc_bit,
   output wire logic        o_rx_hdlc_valid,
   output wire logic        o_rx_ds0_mode
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   logic [7:0]  tx_code_r;
   logic [7:0]  rx_chan_r;
   logic [7:0]  rx_supp_r;
   logic [7:0]  rdata_r;
   logic [2:0]  link_sync_r;
   logic        link_level_r;
   tx_state_t   state_r;
   tx_state_t   state_nxt;
   logic [3:0]  bit_cnt_r;
   logic [3:0]  bit_cnt_nxt;
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic        tx_bit_r;
   logic        rx_bit_r;
   logic        rx_valid_r;
   logic        fifo_valid;
   logic [7:0]  fifo_data;
   logic [CODE_W-1:0] code_snap_r;

   // Register decode
   wire wr_code = i_wr && (i_addr == ADDR_TX_CODE);
   wire wr_fifo = i_wr && (i_addr == ADDR_TX_FIFO);
   wire wr_chan = i_wr && (i_addr == ADDR_RX_CHAN);
   wire wr_supp = i_wr && (i_addr == ADDR_RX_SUPP);
   wire [7:0] rd_mux = (i_addr == ADDR_TX_CODE) ? tx_code_r :
                       (i_addr == ADDR_RX_CHAN) ? rx_chan_r :
                       (i_addr == ADDR_RX_SUPP) ? rx_supp_r : 8'h00;

   // Trigger edges are taken from the write itself, not a resync
   wire code_start = wr_code && i_wdata[TRIG_BIT] && !tx_code_r[TRIG_BIT]; // see [RL13]
   wire code_stop  = wr_code && !i_wdata[TRIG_BIT];                        // see [RL13]
   wire src_ctrl   = tx_code_r[SRC_BIT];
   wire tx_step    = i_tx_fdl_en && src_ctrl;
   // The write that starts a code also carries its codeword, so take it from the bus
   wire [CODE_W-1:0] codeword = wr_code ? i_wdata[CODE_W-1:0] : tx_code_r[CODE_W-1:0]; // see [RL13]
   // Frame goes out index 0 first: 0, codeword LSB..MSB, 0, eight ones
   wire [15:0] code_frame = {CODE_ONES, 1'b0, codeword, 1'b0}; // see [RL2] [RL3]
   wire byte_end   = (bit_cnt_r == BYTE_LAST);
   // A code start in the same cycle wins, so the byte stays queued
   wire pop        = tx_step && (state_r != TX_CODE) && byte_end && fifo_valid && !code_start;

   // Control registers; spare bit 6 is stored as written
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tx_code_r <= TX_CODE_RST;
         rx_chan_r <= RX_CHAN_RST;
         rx_supp_r <= RX_SUPP_RST;
      end else begin
         if (wr_code) tx_code_r <= i_wdata;
         if (wr_chan) rx_chan_r <= i_wdata;
         if (wr_supp) rx_supp_r <= i_wdata;
      end
   end

   // Read data held until the next read; write-only port reads zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) rdata_r <= 8'h00;
      else if (i_rd) rdata_r <= rd_mux;
   end
   assign o_rdata = rdata_r;

   // Link pin resync; a change counts once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         link_sync_r  <= 3'h0;
         link_level_r <= 1'b0;
      end else begin
         link_sync_r <= {link_sync_r[1:0], i_transmit_link_input};
         if (link_sync_r[1] == link_sync_r[2]) link_level_r <= link_sync_r[2];
      end
   end

   // Transmit FIFO; the serialiser stalls while a code is sent or
   // the pin is the source, so the host sees it fill
   byte_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_tx_fifo (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (wr_fifo),   // see [RL4]
      .i_in_data   (i_wdata),   // see [RL5]
      .o_in_ready  (o_fifo_ready),
      .o_out_valid (fifo_valid),
      .o_out_data  (fifo_data),
      .i_out_ready (pop)
   );

   // Serialiser next state; start and stop of a code take priority
   always_comb begin
      state_nxt   = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt   = shift_r;
      if (code_start) begin
         state_nxt   = TX_CODE;                      // see [RL13]
         bit_cnt_nxt = 4'h0;
         shift_nxt   = code_frame;
      end else if (code_stop && state_r == TX_CODE) begin
         state_nxt   = TX_IDLE;                      // see [RL13]
         bit_cnt_nxt = 4'h0;
         shift_nxt   = {8'h00, IDLE_FLAG};
      end else if (tx_step) begin
         case (state_r)
            TX_CODE: begin
               if (bit_cnt_r == CODE_LAST) begin
                  bit_cnt_nxt = 4'h0;
                  shift_nxt   = code_frame;
               end else begin
                  bit_cnt_nxt = bit_cnt_r + 1'b1;
                  shift_nxt   = {1'b0, shift_r[15:1]}; // see [RL3]
               end
            end
            default: begin
               if (byte_end) begin
                  bit_cnt_nxt = 4'h0;
                  state_nxt   = fifo_valid ? TX_DATA : TX_IDLE;
                  // Data bytes go out LSB first, bit 7 last
                  shift_nxt   = {8'h00, fifo_valid ? fifo_data : IDLE_FLAG}; // see [RL5]
               end else begin
                  bit_cnt_nxt = bit_cnt_r + 1'b1;
                  shift_nxt   = {1'b0, shift_r[15:1]};
               end
            end
         endcase
      end
   end

   // Serialiser state
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_r   <= TX_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r   <= {8'h00, IDLE_FLAG};
      end else begin
         state_r   <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r   <= shift_nxt;
      end
   end

   // Codeword of the frame now on the wire; a rewrite mid-frame
   // only reaches the line at the next frame boundary
   wire frame_load = code_start || (tx_step && !code_stop && state_r == TX_CODE && bit_cnt_r == CODE_LAST);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) code_snap_r <= '0;
      else if (frame_load) code_snap_r <= codeword;
   end

   // Outgoing link bit, taken on each link bit strobe
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) tx_bit_r <= 1'b0;
      else if (i_tx_fdl_en) tx_bit_r <= src_ctrl ? shift_r[0] : link_level_r; // see [RL1]
   end
   assign o_tx_fdl_bit   = tx_bit_r;
   assign o_sending_code = (state_r == TX_CODE);

   // Receive bit selection; spare bit 6 is ignored by the hardware
   wire ds0_en     = rx_chan_r[RXEN_BIT];
   wire block_mode = rx_chan_r[MODE_BIT];
   wire [CHAN_W-1:0] chan_sel = rx_chan_r[CHAN_W-1:0];          // see [RL9]
   wire chan_hit   = block_mode ? i_rx_block_hit                // see [RL8]
                                : (i_rx_chan == chan_sel);      // see [RL7]
   wire bit_kept   = !rx_supp_r[i_rx_bitpos];                   // see [RL10] [RL11]
   wire rx_take    = ds0_en ? (chan_hit && bit_kept)            // see [RL14]
                            : i_rx_fdl_slot;                    // see [RL6]

   // Suppressed bits produce no strobe at all, so they leave no gap
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rx_bit_r   <= 1'b0;
         rx_valid_r <= 1'b0;
      end else begin
         rx_valid_r <= i_rx_bit_en && rx_take;
         if (i_rx_bit_en && rx_take) rx_bit_r <= i_rx_bit;
      end
   end
   assign o_rx_hdlc_bit   = rx_bit_r;
   assign o_rx_hdlc_valid = rx_valid_r;
   assign o_rx_ds0_mode   = ds0_en;

   // Transmit checks
   src_pin_a: assert property ( // see [RL1]
      i_tx_fdl_en && !src_ctrl |=> o_tx_fdl_bit == $past(link_level_r))
      else $error("link pin bit not forwarded");
   hold_pin_a: assert property ( // see [RL1]
      !tx_step && !code_start && !(code_stop && o_sending_code)
      |=> $stable(state_r) && $stable(bit_cnt_r) && $stable(shift_r))
      else $error("serialiser moved without a strobe");
   code_last_a: assert property ( // see [RL2]
      tx_step && state_r == TX_CODE && bit_cnt_r == CODE_B5_POS && !wr_code
      |=> o_tx_fdl_bit == code_snap_r[CODE_W-1])
      else $error("codeword bit 5 not in last slot");
   code_first_a: assert property ( // see [RL3]
      tx_step && state_r == TX_CODE && bit_cnt_r == CODE_B0_POS && !wr_code
      |=> o_tx_fdl_bit == code_snap_r[0])
      else $error("codeword bit 0 not in first slot");
   code_ctrl_a: assert property ( // see [RL13]
      code_start |=> o_sending_code && bit_cnt_r == 4'h0 && code_snap_r == $past(i_wdata[CODE_W-1:0]))
      else $error("code start not honoured");
   code_stop_a: assert property ( // see [RL13]
      code_stop && !code_start |=> !o_sending_code)
      else $error("code stop not honoured");

   // FIFO checks
   fifo_push_a: assert property ( // see [RL4]
      wr_fifo && o_fifo_ready && !fifo_valid |=> fifo_valid)
      else $error("fifo write did not store a byte");
   fifo_full_a: assert property ( // see [RL4]
      wr_fifo && !o_fifo_ready && !pop |=> !o_fifo_ready)
      else $error("write to a full fifo changed its level");
   idle_fill_a: assert property ( // see [RL4]
      tx_step && state_r != TX_CODE && byte_end && !fifo_valid && !wr_code
      |=> state_r == TX_IDLE && shift_r[7:0] == IDLE_FLAG)
      else $error("empty fifo did not give idle fill");
   data_order_a: assert property ( // see [RL5]
      pop |=> shift_r[7:0] == $past(fifo_data) && state_r == TX_DATA)
      else $error("popped byte not loaded LSB first");
   data_step_a: assert property ( // see [RL5]
      tx_step && state_r == TX_DATA && !byte_end && !wr_code
      |=> bit_cnt_r == $past(bit_cnt_r) + 4'h1 && shift_r[6:0] == $past(shift_r[7:1]))
      else $error("data byte not shifted LSB first");

   // Receive checks
   rx_link_a: assert property ( // see [RL6]
      i_rx_bit_en && !ds0_en |=> o_rx_hdlc_valid == $past(i_rx_fdl_slot))
      else $error("link mode did not follow link slots");
   rx_single_a: assert property ( // see [RL7]
      i_rx_bit_en && ds0_en && !block_mode && i_rx_chan != chan_sel
      |=> !o_rx_hdlc_valid)
      else $error("unselected channel reached controller");
   rx_chan_bin_a: assert property ( // see [RL9]
      i_rx_bit_en && ds0_en && !block_mode && !rx_supp_r[i_rx_bitpos]
      && i_rx_chan == 5'(rx_chan_r & 8'h1F) |=> o_rx_hdlc_valid)
      else $error("selected channel number not used");
   rx_block_a: assert property ( // see [RL8]
      i_rx_bit_en && ds0_en && block_mode && !i_rx_block_hit
      |=> !o_rx_hdlc_valid)
      else $error("channel outside block map used");
   rx_msb_drop_a: assert property ( // see [RL10]
      i_rx_bit_en && ds0_en && i_rx_bitpos == 3'h7 && rx_supp_r[7] |=> !o_rx_hdlc_valid)
      else $error("suppressed msb used");
   rx_suppress_a: assert property ( // see [RL11]
      i_rx_bit_en && ds0_en && rx_supp_r[i_rx_bitpos]
      |=> !o_rx_hdlc_valid)
      else $error("suppressed bit used");
   rx_kept_a: assert property ( // see [RL14]
      i_rx_bit_en && ds0_en && chan_hit && bit_kept
      |=> o_rx_hdlc_valid && o_rx_hdlc_bit == $past(i_rx_bit))
      else $error("kept bit not passed on");
endmodule

/* File: verilog/hdlc_cfg_pkg.sv */
/*
 Constants for the HDLC / bit-oriented-code configuration block:
 register offsets, field positions, reset values and FIFO shape.
 Assumes an 8-bit parallel control port with 8-bit offsets.
*/
package hdlc_cfg_pkg;
   // Register offsets on the control port
   localparam logic [7:0] ADDR_TX_CODE = 8'h07;
   localparam logic [7:0] ADDR_TX_FIFO = 8'h08;
   localparam logic [7:0] ADDR_RX_CHAN = 8'h90;
   localparam logic [7:0] ADDR_RX_SUPP = 8'h91;
   // Field positions
   localparam int TRIG_BIT = 7;
   localparam int SRC_BIT  = 6;
   localparam int CODE_W   = 6;
   localparam int RXEN_BIT = 7;
   localparam int MODE_BIT = 5;
   localparam int CHAN_W   = 5;
   // Reset values
   localparam logic [7:0] TX_CODE_RST = 8'h00;
   localparam logic [7:0] RX_CHAN_RST = 8'h00;
   localparam logic [7:0] RX_SUPP_RST = 8'h00;
   // Serialiser shape
   localparam logic [7:0] IDLE_FLAG   = 8'h7E;
   localparam logic [7:0] CODE_ONES   = 8'hFF;
   localparam logic [3:0] CODE_LAST   = 4'hF;
   localparam logic [3:0] BYTE_LAST   = 4'h7;
   localparam logic [3:0] CODE_B0_POS = 4'h1;
   localparam logic [3:0] CODE_B5_POS = 4'h6;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 8;
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_CODE} tx_state_t;
endpackage

/* File: dv/hdlc_bit_code_ds0_config_tb_top.sv */
/*
 Self-checking bench for the HDLC / code configuration block.
 Assumes the design package and modules are compiled before it.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t value differs", $time); end end

module hdlc_bit_code_ds0_config_tb_top;
   import hdlc_cfg_pkg::*;
   logic       i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_tx_fdl_en = 1'b0;
   logic       i_transmit_link_input = 1'b0, i_rx_bit_en = 1'b0, i_rx_bit = 1'b0;
   logic       i_rx_fdl_slot = 1'b0, i_rx_block_hit = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, b, cc, ss;
   logic [4:0] i_rx_chan = 5'h00, c;
   logic [2:0] i_rx_bitpos = 3'h0, p;
   logic       o_fifo_ready, o_tx_fdl_bit, o_sending_code, o_rx_hdlc_bit, o_rx_hdlc_valid, o_rx_ds0_mode;
   logic       rd_s, tx_s, v, f, h, sel;
   logic [7:0] rdq[$];
   logic       txq[$];
   logic       rxq[$];
   logic [7:0] dat[8];
   int         n_mismatch = 0;
   int         checks = 0;

   hdlc_bit_code_ds0_config i_hdlc_bit_code_ds0_config (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_fifo_ready(o_fifo_ready), .i_tx_fdl_en(i_tx_fdl_en),
      .i_transmit_link_input(i_transmit_link_input), .o_tx_fdl_bit(o_tx_fdl_bit),
      .o_sending_code(o_sending_code), .i_rx_bit_en(i_rx_bit_en), .i_rx_bit(i_rx_bit),
      .i_rx_fdl_slot(i_rx_fdl_slot), .i_rx_chan(i_rx_chan), .i_rx_bitpos(i_rx_bitpos),
      .i_rx_block_hit(i_rx_block_hit), .o_rx_hdlc_bit(o_rx_hdlc_bit), .o_rx_hdlc_valid(o_rx_hdlc_valid),
      .o_rx_ds0_mode(o_rx_ds0_mode));

   // 20 MHz clock
   always #25 i_clk = ~i_clk;

   // Result watcher: sampling before inputs move avoids races with the drivers
   always @(posedge i_clk) begin
      rd_s = i_rd;
      tx_s = i_tx_fdl_en;
      #1;
      if (rd_s && rdq.size() > 0) `CHK(o_rdata, rdq.pop_front())
      if (tx_s && txq.size() > 0) `CHK(o_tx_fdl_bit, txq.pop_front())
      if (o_rx_hdlc_valid === 1'b1) begin
         if (rxq.size() == 0) `CHK(1'b1, 1'b0)
         else `CHK(o_rx_hdlc_bit, rxq.pop_front())
      end
   end

   // Control port cycles, one strobe cycle each
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk); #2;
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(posedge i_clk); #2;
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rdq.push_back(e);
      @(posedge i_clk); #2;
      i_rd = 1'b1;
      i_addr = a;
      @(posedge i_clk); #2;
      i_rd = 1'b0;
   endtask
   // One link bit strobe; returns the bit sent
   task automatic strobe(output logic r);
      @(posedge i_clk); #2;
      i_tx_fdl_en = 1'b1;
      @(posedge i_clk); #2;
      i_tx_fdl_en = 1'b0;
      r = o_tx_fdl_bit;
   endtask
   // One receive bit; notes it when it should reach the controller
   task automatic rxb(input logic fs, input logic [4:0] ch, input logic [2:0] ps, input logic hit, input logic s);
      @(posedge i_clk); #2;
      {i_rx_bit_en, i_rx_fdl_slot, i_rx_chan, i_rx_bitpos, i_rx_block_hit} = {1'b1, fs, ch, ps, hit};
      i_rx_bit = 1'($urandom);
      if (s) rxq.push_back(i_rx_bit);
      @(posedge i_clk); #2;
      i_rx_bit_en = 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog: the whole run needs well under 5000 cycles
   initial begin
      #1000000;
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      void'($urandom(89));
      repeat (6) @(posedge i_clk);
      #2 i_rst_n = 1'b1;
      // Reset values, write-only port and unmapped place
      rd(ADDR_TX_CODE, TX_CODE_RST);
      rd(ADDR_RX_CHAN, RX_CHAN_RST);
      rd(ADDR_RX_SUPP, RX_SUPP_RST);
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      rd(ADDR_TX_FIFO, 8'h00);
      $display("test registers done");
      // Source bit 0: link pin is copied, after its resync delay
      for (int i = 0; i < 2; i++) begin
         i_transmit_link_input = 1'(i);
         repeat (5) @(posedge i_clk);
         txq.push_back(1'(i));
         strobe(v);
      end
      $display("test link pin done");
      // Codeword frame: bit 0 first, bit 5 last
      b = 8'($urandom % 64) | 8'hC0;
      wr(ADDR_TX_CODE, b);
      `CHK(o_sending_code, 1'b1)
      rd(ADDR_TX_CODE, b);
      txq.push_back(1'b0);
      for (int i = 0; i < CODE_W; i++) txq.push_back(b[i]);
      txq.push_back(1'b0);
      repeat (8) txq.push_back(1'b1);
      txq.push_back(1'b0);
      txq.push_back(b[0]);
      repeat (18) strobe(v);
      wr(ADDR_TX_CODE, 8'h40);
      `CHK(o_sending_code, 1'b0)
      wr(ADDR_TX_CODE, 8'h00);
      $display("test codeword done");
      // Fill the FIFO until it refuses, then drain it with the serialiser
      for (int i = 0; i < FIFO_D; i++) begin
         dat[i] = 8'($urandom % 126);
         `CHK(o_fifo_ready, 1'b1)
         wr(ADDR_TX_FIFO, dat[i]);
      end
      `CHK(o_fifo_ready, 1'b0)
      wr(ADDR_TX_FIFO, 8'hA5);
      wr(ADDR_TX_CODE, 8'h40);
      for (int k = 0; k < 4 && (k == 0 || b == IDLE_FLAG); k++)
         for (int i = 0; i < 8; i++) strobe(b[i]);
      `CHK(b, dat[0])
      for (int i = 1; i < FIFO_D; i++)
         for (int j = 0; j < 8; j++) txq.push_back(dat[i][j]);
      for (int j = 0; j < 8; j++) txq.push_back(IDLE_FLAG[j]);
      repeat (64) strobe(v);
      `CHK(o_fifo_ready, 1'b1)
      $display("test fifo done");
      // Receive selection: link, single channel twice, channel-block map
      for (int m = 0; m < 4; m++) begin
         cc = {1'(m != 0), 1'b0, 1'(m == 3), 5'($urandom % 24)};
         ss = (m == 0) ? 8'h00 : 8'($urandom);
         wr(ADDR_RX_CHAN, cc);
         wr(ADDR_RX_SUPP, ss);
         rd(ADDR_RX_CHAN, cc);
         rd(ADDR_RX_SUPP, ss);
         `CHK(o_rx_ds0_mode, cc[RXEN_BIT])
         repeat (40) begin
            f = cc[7] ? 1'b0 : 1'($urandom);
            c = ($urandom % 2) ? cc[4:0] : 5'($urandom % 24);
            p = 3'($urandom);
            h = 1'($urandom);
            sel = cc[7] ? ((cc[5] ? h : c == cc[4:0]) && !ss[p]) : f;
            rxb(f, c, p, h, sel);
         end
         $display("test receive mode %0d done", m);
      end
      repeat (3) @(posedge i_clk);
      `CHK(rxq.size() == 0, 1'b1)
      end_of_test();
   end
endmodule
